// ===== ism_pkg.sv
// shared constants and types of the two-wire serial memory slave
package ism_pkg;
    localparam int MEM_BYTES = 2048;
    localparam int ADDR_W = 11;
    localparam int BYTE_W = 8;
    localparam int PAGE_W = 3;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = ADDR_W + BYTE_W;
    // device-type code; value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h5;
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int PAGE_HI = 3;
    localparam int PAGE_LO = 1;
    localparam int RW_BIT = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 11'h7ff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

    typedef enum logic [3:0] {
        ISM_IDLE,
        ISM_ADDR,
        ISM_ADDR_ACK,
        ISM_WORD,
        ISM_WORD_ACK,
        ISM_WDATA,
        ISM_WDATA_ACK,
        ISM_RDATA,
        ISM_RACK
    } ism_state_e;
endpackage

// ===== ism_top.sv
// two-wire serial memory slave: bus protocol engine, write fifo and byte array
//
// How it works
// - sda falling while scl high is detected as a start.
// - sda rising while scl high is detected as a stop.
// - a stop aborts any operation and releases sda.
// - a start aborts everything and waits for a slave address byte.
// - sda is sampled only while scl is high, on its rising edge.
// - after eight bits the sender releases sda; low is ack, high nack.
// - a nack from the master ends the operation; device re-addressable.
// - first byte after start is slave address; upper nibble must match type.
// - address bits three to one select the page, upper address bits.
// - address bit zero: one reads, zero writes.
// - on write, next byte is the low address, latched with page.
// - on read, page latched, low address kept from the internal latch.
// - address increments after each data byte, before ack; wraps to zero.
// - any number of sequential bytes per operation.
// - read sends eight bits, samples ack, continues on ack, ends otherwise.
// - all bytes travel most significant bit first.
// - write receives eight bits then acknowledges accepted bytes.
// - array written at eighth bit before ack; earlier start or stop changes nothing.
// - no write delay; device always ready for the next operation.
// - write protect high: no data byte ack, no array change, no increment.
// - write protect low allows writes; unconnected input reads low.
// - outputs change after scl falls or at a start or stop; inputs captured on scl rise.
`timescale 1ns/1ps

module ism_fifo #(
    parameter int W = 19,
    parameter int D = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ism_fifo_s;

    ism_fifo_s q, d;
    logic push, pop;

    always_comb begin
        d = q;
        push = i_in_valid && (q.cnt != FULL);
        pop = i_out_ready && (q.cnt != '0);
        if (push) begin
            d.mem[q.wr] = i_in_data;
            d.wr = (q.wr == LAST) ? '0 : AW'(q.wr + 1'b1);
        end
        if (pop) begin
            d.rd = (q.rd == LAST) ? '0 : AW'(q.rd + 1'b1);
        end
        if (push && !pop) begin
            d.cnt = (AW+1)'(q.cnt + 1'b1);
        end else if (pop && !push) begin
            d.cnt = (AW+1)'(q.cnt - 1'b1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_in_ready = (q.cnt != FULL);
    assign o_out_valid = (q.cnt != '0);
    assign o_out_data = q.mem[q.rd];
endmodule

module ism_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_wp,
    output logic o_busy
);
    import ism_pkg::*;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic wp_m;
        logic wp_s;
        ism_state_e st;
        logic [3:0] cnt;
        logic [BYTE_W-1:0] sh;
        logic [BYTE_W-1:0] tx;
        logic [ADDR_W-1:0] addr;
        logic rw;
        logic mack;
        logic oe;
        logic push;
        // set at the eighth rise of a data byte when the byte went into the fifo
        logic taken;
        logic [FIFO_W-1:0] pdata;
    } ism_top_s;

    ism_top_s q, d;
    logic [BYTE_W-1:0] mem_q [0:MEM_BYTES-1];
    logic rise, fall, start, stop, ld, accept;
    logic fifo_ready, drain_valid, drain_ready;
    logic [FIFO_W-1:0] drain_data;

    // every sampler below reads the second flop of each synchroniser; the scl and sda edge detectors also read the third
    assign rise = q.scl_s && !q.scl_p;
    assign fall = !q.scl_s && q.scl_p;
    assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
    assign stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
    // the fifo must have room, otherwise the byte is refused like a protected one
    assign accept = !q.wp_s && fifo_ready;

    always_comb begin
        d = q;
        ld = 1'b0;
        d.push = 1'b0;
        d.scl_m = i_scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = i_sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.wp_m = i_wp;
        d.wp_s = q.wp_m;
        if (start) begin
            d.st = ISM_ADDR;
            d.cnt = '0;
            d.oe = 1'b0;
        end else if (stop) begin
            d.st = ISM_IDLE;
            d.oe = 1'b0;
        end else if (rise) begin
            unique case (q.st)
                ISM_ADDR, ISM_WORD, ISM_WDATA: begin
                    d.sh = {q.sh[BYTE_W-2:0], q.sda_s};
                    d.cnt = 4'(q.cnt + 1'b1);
                    if (q.st == ISM_WDATA && q.cnt == LAST_BIT) begin
                        // remembered for the ack: wp or a full fifo both refuse the byte
                        d.taken = accept;
                    end
                    if (q.st == ISM_WDATA && q.cnt == LAST_BIT && accept) begin
                        // array write launched at the eighth bit, long before the ack
                        d.push = 1'b1;
                        d.pdata = {q.addr, q.sh[BYTE_W-2:0], q.sda_s};
                        d.addr = (q.addr == ADDR_TOP) ? ADDR_RST
                                                      : ADDR_W'(q.addr + 1'b1);
                    end
                end
                ISM_RDATA: begin
                    d.cnt = 4'(q.cnt + 1'b1);
                    if (q.cnt == LAST_BIT) begin
                        d.addr = (q.addr == ADDR_TOP) ? ADDR_RST
                                                      : ADDR_W'(q.addr + 1'b1);
                    end
                end
                ISM_RACK: begin
                    d.mack = !q.sda_s;
                end
                ISM_IDLE, ISM_ADDR_ACK, ISM_WORD_ACK, ISM_WDATA_ACK: begin
                end
            endcase
        end else if (fall) begin
            unique case (q.st)
                ISM_ADDR: begin
                    if (q.cnt == BITS_PER_BYTE) begin
                        if (q.sh[TYPE_HI:TYPE_LO] == DEV_TYPE) begin
                            d.addr[ADDR_W-1 -: PAGE_W] = q.sh[PAGE_HI:PAGE_LO];
                            d.rw = q.sh[RW_BIT];
                            d.oe = 1'b1;
                            d.st = ISM_ADDR_ACK;
                        end else begin
                            d.st = ISM_IDLE;
                        end
                    end
                end
                ISM_ADDR_ACK: begin
                    d.cnt = '0;
                    if (q.rw) begin
                        ld = 1'b1;
                        d.tx = mem_q[q.addr];
                        d.oe = !mem_q[q.addr][BYTE_W-1];
                        d.st = ISM_RDATA;
                    end else begin
                        d.oe = 1'b0;
                        d.st = ISM_WORD;
                    end
                end
                ISM_WORD: begin
                    if (q.cnt == BITS_PER_BYTE) begin
                        d.addr[BYTE_W-1:0] = q.sh;
                        d.oe = 1'b1;
                        d.st = ISM_WORD_ACK;
                    end
                end
                ISM_WORD_ACK, ISM_WDATA_ACK: begin
                    d.oe = 1'b0;
                    d.cnt = '0;
                    d.st = ISM_WDATA;
                end
                ISM_WDATA: begin
                    if (q.cnt == BITS_PER_BYTE) begin
                        // the push decided one half-period earlier tells us if we took it
                        // acking a byte the fifo refused would lose it silently
                        if (q.wp_s || !q.taken) begin
                            d.st = ISM_IDLE;
                        end else begin
                            d.oe = 1'b1;
                            d.st = ISM_WDATA_ACK;
                        end
                    end
                end
                ISM_RDATA: begin
                    if (q.cnt == BITS_PER_BYTE) begin
                        d.oe = 1'b0;
                        d.st = ISM_RACK;
                    end else begin
                        d.oe = !q.tx[3'(LAST_BIT - q.cnt[2:0])];
                    end
                end
                ISM_RACK: begin
                    if (q.mack) begin
                        ld = 1'b1;
                        d.cnt = '0;
                        d.tx = mem_q[q.addr];
                        d.oe = !mem_q[q.addr][BYTE_W-1];
                        d.st = ISM_RDATA;
                    end else begin
                        d.st = ISM_IDLE;
                    end
                end
                ISM_IDLE: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                   wp_m: 1'b0, wp_s: 1'b0, st: ISM_IDLE, cnt: '0,
                   sh: BYTE_RST, tx: BYTE_RST, addr: ADDR_RST, rw: 1'b0,
                   mack: 1'b0, oe: 1'b0, push: 1'b0, taken: 1'b0, pdata: '0};
        end else begin
            q <= d;
        end
    end

    // fifo drain pauses while the array is being read, leaving it single-ported
    assign drain_ready = !ld;

    ism_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_wfifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(q.push),
        .o_in_ready(fifo_ready),
        .i_in_data(q.pdata),
        .o_out_valid(drain_valid),
        .i_out_ready(drain_ready),
        .o_out_data(drain_data)
    );

    always_ff @(posedge i_clk) begin
        if (drain_valid && drain_ready) begin
            mem_q[drain_data[FIFO_W-1 -: ADDR_W]] <= drain_data[BYTE_W-1:0];
        end
    end

    // open drain: data low whenever enabled; scl is never driven
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sda_o <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_sda_o <= 1'b0;
            o_busy <= (d.st != ISM_IDLE);
        end
    end
    assign o_sda_oe = q.oe;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_stop_abort: assert property (stop |=> q.st == ISM_IDLE && !q.oe)
        else $error("stop did not abort");
    a_start_addr: assert property (start |=> q.st == ISM_ADDR && q.cnt == 4'h0)
        else $error("start did not rearm address phase");
    a_drive_low: assert property ($rose(q.oe) |-> !$past(q.scl_s))
        else $error("sda driven while scl high");
    a_type_miss: assert property (fall && q.st == ISM_ADDR && q.cnt == BITS_PER_BYTE
            && q.sh[TYPE_HI:TYPE_LO] != DEV_TYPE |=> (!q.oe && q.st == ISM_IDLE)[*3])
        else $error("mismatched address acknowledged");
    a_wp_block: assert property (q.push |-> !$past(q.wp_s))
        else $error("write pushed while protected");
    a_wp_noack: assert property (fall && q.st == ISM_WDATA && q.cnt == BITS_PER_BYTE
            && q.wp_s |=> !q.oe && q.st == ISM_IDLE)
        else $error("protected byte acknowledged");
    a_addr_wrap: assert property (rise && q.st == ISM_RDATA && q.cnt == LAST_BIT
            && q.addr == ADDR_TOP |=> q.addr == ADDR_RST)
        else $error("address did not wrap");
    a_page_latch: assert property (fall && q.st == ISM_ADDR && q.cnt == BITS_PER_BYTE
            && q.sh[TYPE_HI:TYPE_LO] == DEV_TYPE
            |=> q.addr[ADDR_W-1 -: PAGE_W] == $past(q.sh[PAGE_HI:PAGE_LO]) && q.oe)
        else $error("page not latched or no ack");
    a_word_latch: assert property (fall && q.st == ISM_WORD && q.cnt == BITS_PER_BYTE
            |=> q.addr[BYTE_W-1:0] == $past(q.sh) && q.st == ISM_WORD_ACK)
        else $error("word address not latched");
    a_read_nack: assert property (fall && q.st == ISM_RACK && !q.mack
            |=> q.st == ISM_IDLE && !q.oe)
        else $error("read continued after nack");
    a_write_lands: assert property (q.push ##1 !ld |=> mem_q[$past(q.pdata[FIFO_W-1 -: ADDR_W], 2)]
            == $past(q.pdata[BYTE_W-1:0], 2) or q.push)
        else $error("accepted byte not written");

    // sda only ever moves one cycle after a seen scl fall, start or stop
    a_oe_timing: assert property ($changed(q.oe) |-> $past(fall || start || stop))
        else $error("sda enable moved outside a low clock phase");
    a_rd_release: assert property (fall && q.st == ISM_RDATA && q.cnt == BITS_PER_BYTE
            |=> !q.oe && q.st == ISM_RACK)
        else $error("sda not released for master ack");
    a_read_next: assert property (fall && q.st == ISM_RACK && q.mack
            |=> q.st == ISM_RDATA && q.cnt == 4'h0)
        else $error("read did not continue after ack");
    a_write_ack: assert property (fall && q.st == ISM_WDATA && q.cnt == BITS_PER_BYTE
            && q.taken && !q.wp_s |=> q.oe && q.st == ISM_WDATA_ACK)
        else $error("accepted byte not acknowledged");
    // a protected byte must leave the address counter where it was
    a_wp_noincr: assert property (rise && q.st == ISM_WDATA && q.wp_s
            |=> q.addr == $past(q.addr))
        else $error("address moved while protected");
    // the low address byte survives a read slave address untouched
    a_low_keep: assert property (fall && q.st == ISM_ADDR && q.cnt == BITS_PER_BYTE
            && q.sh[TYPE_HI:TYPE_LO] == DEV_TYPE
            |=> q.addr[BYTE_W-1:0] == $past(q.addr[BYTE_W-1:0]))
        else $error("low address lost at slave address");
    a_busy_state: assert property (o_busy == (q.st != ISM_IDLE))
        else $error("busy flag out of step with engine");
    a_sda_data: assert property (!o_sda_o)
        else $error("open drain data not low");
endmodule

// ===== ism_master.sv
// two-wire bus master model: makes scl, pulls sda low or lets it float high
`timescale 1ns/1ps
module ism_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // scl stands high between frames, it is never free running
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // also serves as repeated start: sda is let go while scl is still low
    task automatic start();
        tick(5);
        o_sda_low = 1'b0;
        tick(5);
        o_scl = 1'b1;
        tick(5);
        o_sda_low = 1'b1;
        tick(5);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        tick(5);
        o_sda_low = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(5);
        o_sda_low = 1'b0;
        tick(5);
    endtask
    // sda moves 5 cycles after scl falls, clearing the device hold window
    task automatic bit_io(input logic b, output logic s);
        tick(5);
        o_sda_low = ~b;
        tick(5);
        o_scl = 1'b1;
        tick(5);
        s = i_sda;
        tick(5);
        o_scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] r,
                        output logic ack_in);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            r[i] = s;
        end
        // a one here releases sda for the receiver, or ends a read
        bit_io(ack_out, ack_in);
    endtask
endmodule

// ===== tb_ism_top.sv
// self-checking bench of the two-wire serial memory slave
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_ism_top;
    import ism_pkg::*;
    typedef struct packed {
        logic [2:0] page;
        logic [7:0] word;
        logic [7:0] data;
        logic [7:0] exp;
    } ism_row_s;
    logic i_clk;
    logic i_rst;
    logic i_wp;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic busy;
    wire sda;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] r;
    logic a;
    ism_row_s rows [4] = '{'{3'h7, 8'hff, 8'h3c, 8'h3c}, '{3'h0, 8'h00, 8'hc3, 8'hc3},
                           '{3'h7, 8'h01, 8'h96, 8'h96}, '{3'h2, 8'h80, 8'h5a, 8'h5a}};
    // pull-up: low whenever either side pulls
    assign sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
    ism_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
                 .o_sda_oe(sda_oe), .i_wp(i_wp), .o_busy(busy));
    ism_master MST (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic addr_frame(input logic [2:0] pg, input logic rw, input logic ex);
        MST.start();
        MST.xfer({DEV_TYPE, pg, rw}, 1'b1, r, a);
        `CHK("slave address ack", ex, a)
    endtask
    task automatic set_ptr(input logic [2:0] pg, input logic [7:0] wd);
        addr_frame(pg, 1'b0, 1'b0);
        MST.xfer(wd, 1'b1, r, a);
        `CHK("word address ack", 1'b0, a)
    endtask
    task automatic wbyte(input logic [7:0] d, input logic ex);
        MST.xfer(d, 1'b1, r, a);
        `CHK("write data ack", ex, a)
    endtask
    task automatic rbyte(input logic ack_out, input logic [7:0] ex);
        MST.xfer(8'hff, ack_out, r, a);
        `CHK("read data", ex, r)
    endtask
    task automatic done(input string nm);
        MST.stop();
        `CHK("busy after stop", 1'b0, busy)
        `CHK("open drain data level", 1'b0, sda_o)
        `CHK("sda released after stop", 1'b0, sda_oe)
        $display("test %s done", nm);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        i_rst = 1'b1;
        i_wp = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK("sda enable in reset", 1'b0, sda_oe)
        `CHK("busy in reset", 1'b0, busy)
        i_rst = 1'b0;
        MST.tick(4);
        $display("test reset done");
        foreach (rows[i]) begin
            set_ptr(rows[i].page, rows[i].word);
            wbyte(rows[i].data, 1'b0);
            MST.stop();
            set_ptr(rows[i].page, rows[i].word);
            addr_frame(rows[i].page, 1'b1, 1'b0);
            rbyte(1'b1, rows[i].exp);
            done("row");
        end
        // sequential write and read across the top of the array
        set_ptr(3'h7, 8'hff);
        wbyte(8'ha1, 1'b0);
        wbyte(8'hb2, 1'b0);
        MST.stop();
        set_ptr(3'h7, 8'hff);
        addr_frame(3'h7, 1'b1, 1'b0);
        rbyte(1'b0, 8'ha1);
        rbyte(1'b1, 8'hb2);
        MST.stop();
        // latch low byte is now 01; new page comes from the slave address
        addr_frame(3'h7, 1'b1, 1'b0);
        rbyte(1'b1, 8'h96);
        done("wrap");
        i_wp = 1'b1;
        set_ptr(3'h2, 8'h80);
        wbyte(8'hff, 1'b1);
        MST.stop();
        i_wp = 1'b0;
        addr_frame(3'h2, 1'b1, 1'b0);
        rbyte(1'b1, 8'h5a);
        done("protect");
        set_ptr(3'h3, 8'h10);
        wbyte(8'h77, 1'b0);
        MST.stop();
        set_ptr(3'h3, 8'h10);
        repeat (5) MST.bit_io(1'b0, a);
        MST.stop();
        set_ptr(3'h3, 8'h10);
        addr_frame(3'h3, 1'b1, 1'b0);
        rbyte(1'b1, 8'h77);
        done("abort");
        MST.start();
        MST.xfer({~DEV_TYPE, 3'h0, 1'b0}, 1'b1, r, a);
        `CHK("foreign type ack", 1'b1, a)
        MST.xfer(8'h00, 1'b1, r, a);
        `CHK("released after foreign type", 1'b1, a)
        done("foreign");
        report_and_stop();
    end
endmodule
